// ==== hdl/pi_engine_pkg.sv ====
package pi_engine_pkg;

  // ==========================================================
  // formats and widths
  // ==========================================================
  localparam int unsigned PI_BYTES  = 8;
  localparam logic [7:0]  PI_LEN    = 8'h08;
  localparam logic [15:0] APP_ESC   = 16'hFFFF;
  localparam logic [31:0] REF_ESC   = 32'hFFFFFFFF;
  localparam logic [15:0] CRC_POLY  = 16'h8BB7;
  localparam logic [15:0] CRC_INIT  = 16'h0000;
  localparam logic [1:0]  BUF_DEPTH = 2'h2;
  // byte index of the application tag high byte inside the field
  localparam logic [2:0]  APP_HI_IDX = 3'h2;

  typedef enum logic [1:0] {
    OP_READ    = 2'h0,
    OP_WRITE   = 2'h1,
    OP_COMPARE = 2'h2
  } op_t;

  typedef enum logic [1:0] {
    PI_NONE  = 2'h0,
    PI_TYPE1 = 2'h1,
    PI_TYPE2 = 2'h2,
    PI_TYPE3 = 2'h3
  } pi_type_t;

  typedef enum logic [1:0] {
    ST_OK    = 2'h0,
    ST_GUARD = 2'h1,
    ST_APP   = 2'h2,
    ST_REF   = 2'h3
  } status_t;

  typedef struct packed {
    op_t         op;
    logic        pi_action_bit;
    logic [2:0]  pi_check_select;
    logic [15:0] expected_app_tag;
    logic [15:0] app_tag_mask;
    logic [31:0] initial_ref_tag;
    logic [15:0] nblocks;
  } cmd_t;

  typedef struct packed {
    pi_type_t    pi_type;
    logic        pi_first;
    logic [15:0] data_bytes;
    logic [7:0]  meta_bytes;
  } ns_fmt_t;

  typedef struct packed {
    logic [15:0] guard;
    logic [15:0] app;
    logic [31:0] ref_tag;
  } pi_field_t;

  // msb-first, zero seed, no final inversion
  function automatic logic [15:0] crc16_byte(input logic [15:0] crc, input logic [7:0] b);
    logic [15:0] c;
    c = crc ^ {b, 8'h00};
    for (int i = 0; i < 8; i++) begin
      c = c[15] ? ({c[14:0], 1'b0} ^ CRC_POLY) : {c[14:0], 1'b0};
    end
    return c;
  endfunction : crc16_byte

endpackage : pi_engine_pkg

// ==== hdl/e2e_protection_info_engine.sv ====
`timescale 1ns/10ps
module e2e_protection_info_engine
  import pi_engine_pkg::*;
(
  input  wire logic                     mclk,
  input  wire logic                     sys_rst,
  input  wire logic                     cmd_start,
  input  wire pi_engine_pkg::cmd_t      cmd,
  input  wire pi_engine_pkg::ns_fmt_t   ns_fmt,
  input  wire logic                     in_valid,
  output logic                          in_ready,
  input  wire logic [7:0]               in_byte,
  output logic                          out_valid,
  input  wire logic                     out_ready,
  output logic [7:0]                    out_byte,
  output logic                          busy,
  output logic                          cmd_done,
  output pi_engine_pkg::status_t        done_status
);
  import pi_engine_pkg::*;

  // ==========================================================
  // state
  // ==========================================================
  typedef enum logic [2:0] {
    S_IDLE  = 3'b001,
    S_RUN   = 3'b010,
    S_DRAIN = 3'b100
  } fsm_t;

  typedef struct packed {
    fsm_t        fsm;
    cmd_t        cmd;
    ns_fmt_t     fmt;
    logic [16:0] pos;
    logic [15:0] blk;
    logic [15:0] crc;
    logic [31:0] ref_tag;
    logic [63:0] pi_buf;
    status_t     status;
    logic        done;
    logic [1:0]  cnt;
    logic [7:0]  buf0;
    logic [7:0]  buf1;
  } state_t;

  state_t st_ff;
  state_t nxt_st;

  logic        pi_on;
  logic        insert;
  logic        strip;
  logic        in_meta;
  logic [7:0]  mi;
  logic [7:0]  pi_start;
  logic [7:0]  pi_off;
  logic        pi_pos;
  logic [2:0]  pi_idx;
  logic        gen_only;
  logic        emit;
  logic        room;
  logic        step;
  logic        push;
  logic        pop;
  logic        blk_end;
  logic        last_blk;
  logic        do_chk;
  logic        esc;
  logic        guard_bad;
  logic        app_bad;
  logic        ref_bad;
  logic [16:0] total;
  logic [16:0] mi_wide;
  logic [7:0]  push_byte;
  pi_field_t   pi_full;
  pi_field_t   pi_gen;

  // ==========================================================
  // datapath decode
  // ==========================================================
  always_comb begin
    pi_on    = st_ff.fmt.pi_type != PI_NONE;
    insert   = pi_on && st_ff.cmd.op == OP_WRITE && st_ff.cmd.pi_action_bit;
    strip    = pi_on && st_ff.cmd.op != OP_WRITE && st_ff.cmd.pi_action_bit
               && st_ff.fmt.meta_bytes == PI_LEN;
    total    = {1'b0, st_ff.fmt.data_bytes} + {9'h000, st_ff.fmt.meta_bytes};
    in_meta  = st_ff.pos >= {1'b0, st_ff.fmt.data_bytes};
    mi_wide  = st_ff.pos - {1'b0, st_ff.fmt.data_bytes};
    mi       = mi_wide[7:0];
    pi_start = st_ff.fmt.pi_first ? 8'h00 : st_ff.fmt.meta_bytes - PI_LEN;
    pi_off   = mi - pi_start;
    pi_pos   = pi_on && in_meta && mi >= pi_start && pi_off < PI_LEN;
    pi_idx   = pi_off[2:0];
    // insert with bare pi metadata: host sends no field bytes at all
    gen_only = insert && st_ff.fmt.meta_bytes == PI_LEN && pi_pos;
    emit     = st_ff.cmd.op != OP_COMPARE && !(strip && pi_pos);
    room     = st_ff.cnt < BUF_DEPTH;
    step     = st_ff.fsm == S_RUN && (gen_only || in_valid) && (!emit || room);
    push     = step && emit;
    pop      = out_valid && out_ready;
    blk_end  = step && st_ff.pos == total - 17'h00001;
    last_blk = st_ff.blk == st_ff.cmd.nblocks - 16'h0001;
    pi_gen   = '{guard: st_ff.crc, app: st_ff.cmd.expected_app_tag,
                 ref_tag: st_ff.ref_tag};
    push_byte = (insert && pi_pos) ? pi_gen[63 - 8 * pi_idx -: 8] : in_byte;
    pi_full  = pi_pos ? {st_ff.pi_buf[55:0], in_byte} : st_ff.pi_buf;
    do_chk   = pi_on && !insert;
    esc      = (st_ff.fmt.pi_type == PI_TYPE3)
               ? (pi_full.app == APP_ESC && pi_full.ref_tag == REF_ESC)
               : (pi_full.app == APP_ESC);
    guard_bad = st_ff.cmd.pi_check_select[2] && pi_full.guard != st_ff.crc;
    app_bad   = st_ff.cmd.pi_check_select[1]
                && ((pi_full.app ^ st_ff.cmd.expected_app_tag)
                    & st_ff.cmd.app_tag_mask) != 16'h0000;
    ref_bad   = st_ff.cmd.pi_check_select[0] && pi_full.ref_tag != st_ff.ref_tag;
  end

  // ==========================================================
  // next state
  // ==========================================================
  always_comb begin
    nxt_st      = st_ff;
    nxt_st.done = 1'b0;
    // two-entry output buffer; head always in buf0
    unique case ({push, pop})
      2'b10: begin
        if (st_ff.cnt == 2'h0) begin
          nxt_st.buf0 = push_byte;
        end else begin
          nxt_st.buf1 = push_byte;
        end
        nxt_st.cnt = st_ff.cnt + 2'h1;
      end
      2'b01: begin
        nxt_st.buf0 = st_ff.buf1;
        nxt_st.cnt  = st_ff.cnt - 2'h1;
      end
      2'b11: begin
        nxt_st.buf0 = (st_ff.cnt == 2'h1) ? push_byte : st_ff.buf1;
        nxt_st.buf1 = push_byte;
      end
      2'b00: begin
      end
    endcase
    unique case (st_ff.fsm)
      S_IDLE: begin
        if (cmd_start) begin
          // fused halves arrive as two ordinary commands
          nxt_st.fsm     = S_RUN;
          nxt_st.cmd     = cmd;
          nxt_st.fmt     = ns_fmt;
          nxt_st.pos     = '0;
          nxt_st.blk     = '0;
          nxt_st.crc     = CRC_INIT;
          nxt_st.ref_tag = cmd.initial_ref_tag;
          nxt_st.status  = ST_OK;
        end
      end
      S_RUN: begin
        if (step) begin
          // crc covers data, plus metadata ahead of a trailing field
          if (!in_meta || (!st_ff.fmt.pi_first && mi < pi_start)) begin
            nxt_st.crc = crc16_byte(st_ff.crc, in_byte);
          end
          if (pi_pos && !insert) begin
            nxt_st.pi_buf = {st_ff.pi_buf[55:0], in_byte};
          end
          nxt_st.pos = st_ff.pos + 17'h00001;
          if (blk_end) begin
            if (do_chk && !esc && st_ff.status == ST_OK) begin
              if (guard_bad) begin
                nxt_st.status = ST_GUARD;
              end else if (app_bad) begin
                nxt_st.status = ST_APP;
              end else if (ref_bad) begin
                nxt_st.status = ST_REF;
              end
            end
            nxt_st.pos     = '0;
            nxt_st.crc     = CRC_INIT;
            nxt_st.ref_tag = st_ff.ref_tag + 32'h00000001;
            nxt_st.blk     = st_ff.blk + 16'h0001;
            if (last_blk) begin
              nxt_st.fsm = S_DRAIN;
            end
          end
        end
      end
      S_DRAIN: begin
        // completion waits until every delivered byte has left
        if (st_ff.cnt == 2'h0) begin
          nxt_st.fsm  = S_IDLE;
          nxt_st.done = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_ff <= '{fsm: S_IDLE, status: ST_OK, crc: CRC_INIT, default: '0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign in_ready    = st_ff.fsm == S_RUN && !gen_only && (!emit || room);
  assign out_valid   = st_ff.cnt != 2'h0;
  assign out_byte    = st_ff.buf0;
  assign busy        = st_ff.fsm != S_IDLE;
  assign cmd_done    = st_ff.done;
  assign done_status = st_ff.status;

  // ==========================================================
  // checks
  // ==========================================================
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  sequence drain_empty;
    st_ff.fsm == S_DRAIN && st_ff.cnt == 2'h0;
  endsequence
  sequence done_pulse;
    cmd_done ##1 !cmd_done;
  endsequence

  chk_compare_silent: assert property (
    st_ff.fsm != S_IDLE && st_ff.cmd.op == OP_COMPARE |-> !out_valid && !push)
    else $error("compare delivered data");
  chk_strip_drop: assert property (
    step && strip && pi_pos |=> st_ff.cnt == $past(st_ff.cnt) - {1'b0, $past(pop)})
    else $error("stripped field byte was delivered");
  chk_no_strip_big: assert property (
    step && pi_pos && st_ff.cmd.op == OP_READ && st_ff.fmt.meta_bytes > PI_LEN |-> push)
    else $error("field stripped with extra metadata");
  chk_guard_err: assert property (
    blk_end && do_chk && !esc && guard_bad && st_ff.status == ST_OK
    |=> st_ff.status == ST_GUARD)
    else $error("guard mismatch not reported");
  chk_app_masked: assert property (
    blk_end && do_chk && !esc && !guard_bad && st_ff.status == ST_OK
    && ((pi_full.app ^ st_ff.cmd.expected_app_tag) & st_ff.cmd.app_tag_mask) == 16'h0000
    |=> st_ff.status != ST_APP)
    else $error("masked tag bit caused failure");
  chk_ref_start: assert property (
    st_ff.fsm == S_IDLE && cmd_start |=> st_ff.ref_tag == $past(cmd.initial_ref_tag))
    else $error("reference tag not seeded");
  chk_ref_incr: assert property (
    blk_end |=> st_ff.ref_tag == $past(st_ff.ref_tag) + 32'h00000001)
    else $error("reference tag did not advance");
  chk_escape_skip: assert property (
    blk_end && esc && st_ff.status == ST_OK |=> st_ff.status == ST_OK)
    else $error("escaped block was checked");
  chk_insert_tag: assert property (
    push && insert && pi_pos && pi_idx == APP_HI_IDX
    |-> push_byte == st_ff.cmd.expected_app_tag[15:8])
    else $error("inserted application tag wrong");
  chk_done_drain: assert property (
    drain_empty |=> done_pulse)
    else $error("completion not signalled after drain");
  chk_first_fail: assert property (
    st_ff.status != ST_OK && st_ff.fsm != S_IDLE |=> $stable(st_ff.status))
    else $error("first failure overwritten");

endmodule : e2e_protection_info_engine

// ==== dv/media_sink.sv ====
`timescale 1ns/10ps
module media_sink (
  input  wire logic       mclk,
  input  wire logic       hold,
  input  wire logic       out_valid,
  input  wire logic [7:0] out_byte,
  output logic            out_ready
);
  // ==========================================
  // stalling receiver
  // ==========================================
  logic [7:0] got[$];
  int         seed = 41;
  // random stalls keep the two-entry buffer busy; one process drives the pin
  initial begin
    out_ready = 1'b0;
    forever @(negedge mclk) out_ready <= !hold && (($random(seed) & 3) != 0);
  end
  always @(posedge mclk) if (out_valid && out_ready) got.push_back(out_byte);
endmodule : media_sink

// ==== dv/tb.sv ====
`timescale 1ns/10ps
module tb;
  import pi_engine_pkg::*;
  // ==========================================
  // stimulus and bookkeeping
  // ==========================================
  logic       mclk = 0, sys_rst = 1, cmd_start = 0, in_valid = 0, hold = 0;
  logic [7:0] in_byte = 8'h00, out_byte;
  cmd_t       cmd = '0;
  ns_fmt_t    ns_fmt = '0;
  logic       in_ready, out_valid, out_ready, busy, cmd_done;
  status_t    done_status;
  int         bad_count = 0, compares = 0, cyc = 0, seed = 41;
  logic [7:0] exp_q[$];
  always #2.5 mclk = ~mclk;
  e2e_protection_info_engine u_dut (.mclk(mclk), .sys_rst(sys_rst), .cmd_start(cmd_start),
    .cmd(cmd), .ns_fmt(ns_fmt), .in_valid(in_valid), .in_ready(in_ready), .in_byte(in_byte),
    .out_valid(out_valid), .out_ready(out_ready), .out_byte(out_byte), .busy(busy),
    .cmd_done(cmd_done), .done_status(done_status));
  media_sink u_sink (.mclk(mclk), .hold(hold), .out_valid(out_valid), .out_byte(out_byte),
    .out_ready(out_ready));
  task conclude;
    $display("compares %0d errors %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : conclude
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      conclude();
    end
  end
  task automatic chk(input logic [63:0] seen, input logic [63:0] want);
    compares++;
    if (seen !== want) begin
      bad_count++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, want);
    end
  endtask : chk
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
    c = c ^ {b, 8'h00};
    for (int i = 0; i < 8; i++) c = c[15] ? ({c[14:0], 1'b0} ^ CRC_POLY) : {c[14:0], 1'b0};
    return c;
  endfunction : crc_step
  // entered at a falling edge, leaves at the falling edge after the byte is taken
  task automatic put(input logic [7:0] b);
    in_valid = 1;
    in_byte = b;
    #1;
    while (in_ready !== 1'b1) begin
      @(negedge mclk);
      #1;
    end
    @(negedge mclk);
  endtask : put
  // ==========================================
  // one command against the reference model
  // ==========================================
  task automatic run(input op_t op, input logic act, input logic [2:0] sel,
      input pi_type_t ty, input logic first, input logic [7:0] mb, input logic [15:0] nb,
      input logic [15:0] mask, input logic [15:0] appv, input logic [15:0] xg,
      input logic [31:0] xr, input logic [31:0] lba, input logic stl);
    logic [7:0]  blk[$];
    logic [15:0] crc;
    logic [63:0] fld;
    int          db, fo, k;
    status_t     st;
    bit          on, ins, strip, skip;
    db = 1 + ($random(seed) & 3);
    if (lba == 0) lba = $random(seed);
    else if (xr == 32'hFFFFFFFF) begin
      // escape case: stored tag is the start tag itself
      xr = 32'h00000000;
    end
    st = ST_OK;
    exp_q = {};
    u_sink.got = {};
    on = ty != PI_NONE;
    ins = on && act && op == OP_WRITE;
    strip = on && act && op != OP_WRITE && mb == PI_LEN;
    fo = first ? 0 : mb - 8;
    cmd = '{op, act, sel, 16'h1234, mask, lba, nb};
    ns_fmt = '{ty, first, 16'(db), mb};
    cmd_start = 1;
    @(negedge mclk);
    cmd_start = 0;
    chk(busy, 1);
    hold = stl;
    // hold the receiver off until the buffer must refuse
    if (stl) fork
      begin
        repeat (12) @(negedge mclk);
        #1;
        chk(in_ready, 0);
        chk(out_valid, 1);
        hold = 0;
      end
    join_none
    for (int b = 0; b < nb; b++) begin
      blk = {};
      crc = CRC_INIT;
      for (k = 0; k < db + mb; k++) blk.push_back(8'($random(seed)));
      for (k = 0; k < db + fo; k++) crc = crc_step(crc, blk[k]);
      fld = {crc ^ xg, appv, (lba + b) ^ xr};
      if (ins) fld = {crc, 16'h1234, lba + b};
      for (k = 0; k < 8; k++) blk[db + fo + k] = fld[63 - 8 * k -: 8];
      skip = !on || ins || (fld[47:32] == APP_ESC && (ty != PI_TYPE3 || fld[31:0] == REF_ESC));
      if (!skip && st == ST_OK) begin
        if (sel[2] && fld[63:48] != crc) st = ST_GUARD;
        else if (sel[1] && ((fld[47:32] ^ 16'h1234) & mask) != 0) st = ST_APP;
        else if (sel[0] && fld[31:0] != lba + b) st = ST_REF;
      end
      for (k = 0; k < db + mb; k++) begin
        if (!(ins && mb == PI_LEN && k >= db))
          put((ins && k >= db + fo && k < db + fo + 8) ? ~blk[k] : blk[k]);
        if (op != OP_COMPARE && !(strip && k >= db + fo)) exp_q.push_back(blk[k]);
      end
    end
    in_valid = 0;
    k = 0;
    while (cmd_done !== 1'b1 && k < 500) begin
      @(posedge mclk);
      #1;
      k++;
    end
    chk(cmd_done, 1);
    chk(done_status, st);
    chk(u_sink.got.size(), exp_q.size());
    foreach (exp_q[i]) chk(u_sink.got[i], exp_q[i]);
    chk(busy, 0);
    @(negedge mclk);
  endtask : run
  // ==========================================
  // scenarios: op act sel type first meta blocks mask app xg xr lba stall
  // ==========================================
  initial begin
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    sys_rst = 0;
    chk(busy, 0);
    chk(out_valid, 0);
    run(OP_READ, 0, 7, PI_TYPE1, 1, 8, 3, 16'hFFFF, 16'h1234, 0, 0, 0, 1);
    run(OP_READ, 1, 7, PI_TYPE1, 1, 8, 2, 16'hFFFF, 16'h1234, 0, 0, 0, 0);
    run(OP_READ, 1, 7, PI_TYPE2, 0, 16, 2, 16'hFFFF, 16'h1234, 0, 0, 0, 0);
    run(OP_COMPARE, 1, 7, PI_TYPE1, 1, 8, 2, 16'hFFFF, 16'h1234, 0, 1, 0, 0);
    run(OP_WRITE, 0, 7, PI_TYPE1, 0, 12, 2, 16'hFFFF, 16'h1234, 16'h0100, 0, 0, 0);
    run(OP_WRITE, 1, 7, PI_TYPE1, 1, 8, 2, 16'hFFFF, 16'h0000, 0, 0, 0, 0);
    run(OP_WRITE, 1, 0, PI_TYPE3, 0, 16, 1, 16'hFFFF, 16'h0000, 0, 0, 0, 0);
    run(OP_READ, 0, 2, PI_TYPE1, 1, 8, 2, 16'h00FF, 16'h5634, 0, 0, 0, 0);
    run(OP_READ, 0, 2, PI_TYPE1, 1, 8, 2, 16'hFF00, 16'h5634, 0, 0, 0, 0);
    run(OP_READ, 0, 1, PI_TYPE2, 1, 8, 3, 16'hFFFF, 16'h1234, 0, 1, 0, 0);
    run(OP_READ, 0, 7, PI_TYPE1, 1, 8, 1, 16'hFFFF, 16'hFFFF, 1, 1, 0, 0);
    run(OP_READ, 0, 7, PI_TYPE3, 1, 8, 1, 16'h0000, 16'hFFFF, 0, 1, 0, 0);
    // start tag all ones, so the single block carries both escape values
    run(OP_READ, 0, 7, PI_TYPE3, 1, 8, 1, 16'hFFFF, 16'hFFFF, 1, 0, 32'hFFFFFFFF, 0);
    run(OP_READ, 0, 7, PI_TYPE1, 1, 8, 2, 16'hFFFF, 16'h0000, 1, 1, 0, 0);
    run(OP_READ, 0, 0, PI_TYPE1, 1, 8, 1, 16'hFFFF, 16'h1234, 1, 1, 0, 0);
    run(OP_READ, 1, 7, PI_NONE, 1, 8, 1, 16'hFFFF, 16'h1234, 1, 0, 0, 0);
    conclude();
  end
endmodule : tb
